//--- rtl/ao_skid_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Holds up to two words so a drain stall loses nothing.
`timescale 1ns/1ps
`default_nettype none
module ao_skid_buffer (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Fill side.
    input  wire logic                  inValid,
    input  var  dac_update_pkg::ao_word_t inWord,
    output logic                       inReady,
    // Drain side.
    output logic                       outValid,
    output var  dac_update_pkg::ao_word_t outWord,
    input  wire logic                  outReady
);
    // Storage array and occupancy.
    dac_update_pkg::ao_word_t slots [0:1];
    dac_update_pkg::ao_word_t next_slot0;
    dac_update_pkg::ao_word_t next_slot1;
    logic [1:0]               count;
    logic [1:0]               next_count;
    logic                     doPush;
    logic                     doPop;

    assign inReady  = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outWord  = slots[0];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    // Next slot contents; slot 0 is always the oldest word.
    always_comb begin
        next_slot0 = slots[0];
        next_slot1 = slots[1];
        next_count = count;
        if (doPop) begin
            next_slot0 = slots[1];
        end
        if (doPush) begin
            // A push lands behind whatever remains after a pop.
            if ((count - {1'b0, doPop}) == 2'h0) begin
                next_slot0 = inWord;
            end else begin
                next_slot1 = inWord;
            end
        end
        next_count = count + {1'b0, doPush} - {1'b0, doPop};
    end

    // Register the buffer state.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count    <= 2'h0;
            slots[0] <= '0;
            slots[1] <= '0;
        end else begin
            count    <= next_count;
            slots[0] <= next_slot0;
            slots[1] <= next_slot1;
        end
    end
endmodule // ao_skid_buffer
`default_nettype wire

//--- rtl/dac_update_cfg.svh
// Purpose: Offsets and reset values for the dual output update block.
// Assumes: Byte offsets on the local board bus, 16-bit data.
// Notes:   Definitions only.
`ifndef DAC_UPDATE_CFG_SVH
`define DAC_UPDATE_CFG_SVH
`define AO_CH0_DATA_OFS   5'h10
`define AO_CH1_DATA_OFS   5'h12
`define AO_UPDATE_OFS     5'h18
`define AO_CODE_RESET     16'h0000
`define AO_BIPOLAR_ZERO   16'h0000
`define AO_MODE_RESET     2'h0
`endif

//--- rtl/dac_update_pkg.sv
// Purpose: Types shared by the dual output update block.
// Assumes: Constants live in dac_update_cfg.svh.
// Notes:   Modes and carried words.
package dac_update_pkg;
    // Output data path selection.
    typedef enum logic [1:0] {
        PATH_DIRECT   = 2'h0,
        PATH_FIFO     = 2'h1,
        PATH_SERIAL   = 2'h2,
        PATH_RESERVED = 2'h3
    } path_mode_t;
    // One channel word travelling toward a converter.
    typedef struct packed {
        logic        channel;
        logic [15:0] code;
    } ao_word_t;
endpackage

//--- rtl/dual_dac_output_update.sv
// Purpose: Digital control for two 16-bit analog output converter channels.
// Assumes: Local bus strobes synchronous to clk; write-only data registers.
// Notes:   Mode, update method and polarity are plain control inputs.
//          Posted updates move both held codes out together at one edge.
//          A word left in the buffer by a mode change is drained and dropped while convReady is high.
//
// Behaviour
// (R1) Mode selects direct, FIFO or serial path.
// (R2) Immediate mode applies written value at once.
// (R3) Posted mode waits for trigger fall or strobe.
// (R4) FIFO bypassed in immediate and serial modes; the code bypasses it only in serial and immediate direct.
// (R5) Per-channel unipolar or bipolar setting kept.
// (R6) Channel 0 data register at 10 hex.
// (R7) Channel 1 data register at 12 hex.
// (R8) Unipolar codes are straight binary 0 to 65535.
// (R9) Bipolar codes are two's complement, 8000 lowest.
// (R10) Outputs hold last code; defined after reset.
`timescale 1ns/1ps
`default_nettype none
`include "dac_update_cfg.svh"
module dual_dac_output_update (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Local register bus.
    input  wire logic        busWrite,
    input  wire logic        busAccess,
    input  wire logic [4:0]  busAddr,
    input  wire logic [15:0] busData,
    // Control settings.
    input  wire logic [1:0]  pathMode,
    input  wire logic        postedUpdate,
    input  wire logic [1:0]  bipolarMode,
    // Serial path word from the companion processor.
    input  wire logic        serialValid,
    input  wire logic        serialChannel,
    input  wire logic [15:0] serialCode,
    // Timer update trigger, active low.
    input  wire logic        timer_update_trigger_n,
    // Converter side.
    input  wire logic        convReady,
    output logic [15:0]      dacCode0,
    output logic [15:0]      dacCode1,
    output logic [1:0]       dacLoad,
    output logic [1:0]       dacBipolar,
    output logic             busReady
);
    // Decoded path mode.
    dac_update_pkg::path_mode_t mode;
    // Pending posted values.
    logic [15:0] held0;
    logic [15:0] held1;
    logic [15:0] next_held0;
    logic [15:0] next_held1;
    // Next values of the registered outputs.
    logic [15:0] next_dacCode0;
    logic [15:0] next_dacCode1;
    logic [1:0]  next_dacLoad;
    logic [1:0]  next_dacBipolar;
    logic        next_busReady;
    // Previous trigger level for falling edge detection.
    logic        trigPrev;
    logic        trigFall;
    logic        updateStrobe;
    // Buffer connections.
    logic                     useFifo;
    logic                     fillValid;
    dac_update_pkg::ao_word_t fillWord;
    logic                     fillReady;
    logic                     drainValid;
    dac_update_pkg::ao_word_t drainWord;
    logic                     drainReady;
    // Occupancy decode, so busReady can look one edge ahead.
    logic                     bufFull;
    logic                     bufOne;
    logic                     doDrain;
    // Source word before the buffer decision.
    logic                     srcValid;
    dac_update_pkg::ao_word_t srcWord;
    logic                     immediate;

    // Decode a data register write into a channel word.
    // Only the two channel data offsets count; the strobe carries no data.
    function automatic logic is_data_write(input logic wr, input logic [4:0] addr);
        return wr && ((addr == `AO_CH0_DATA_OFS) || (addr == `AO_CH1_DATA_OFS));
    endfunction

    // Code 3 is kept and decodes like the FIFO path.
    assign mode = dac_update_pkg::path_mode_t'(pathMode);
    // (R4) FIFO bypass choice
    assign useFifo = !(mode == dac_update_pkg::PATH_SERIAL)
                     && !((mode == dac_update_pkg::PATH_DIRECT) && !postedUpdate);
    // Immediate update is simply the absence of posting.
    assign immediate = !postedUpdate;
    // (R3) Trigger edge and strobe
    // A fall needs the pin high at one edge and low at the next.
    assign trigFall     = trigPrev && !timer_update_trigger_n;
    // The strobe is any access at its offset, read or write alike.
    assign updateStrobe = busAccess && (busAddr == `AO_UPDATE_OFS);

    // Buffer occupancy read back from its handshake flags: a refused fill
    // means two words, a ready fill with a valid drain means exactly one.
    assign bufFull = !fillReady;
    assign bufOne  = fillReady && drainValid;
    assign doDrain = drainValid && drainReady;

    // (R1) Source selection by mode
    always_comb begin
        srcValid     = 1'b0;
        srcWord.channel = 1'b0;
        srcWord.code    = busData;
        if (mode == dac_update_pkg::PATH_SERIAL) begin
            // The serial word carries its own channel and skips the bus.
            srcValid        = serialValid;
            srcWord.channel = serialChannel;
            srcWord.code    = serialCode;
        end else begin
            // (R6) (R7) Register decode
            // A data write counts only at an edge where busReady is high.
            srcValid        = is_data_write(busWrite, busAddr) && busReady;
            srcWord.channel = (busAddr == `AO_CH1_DATA_OFS);
        end
    end

    // Words pass through the buffer in every mode except serial and immediate direct.
    assign fillValid  = srcValid && useFifo;
    assign fillWord   = srcWord;
    assign drainReady = convReady;

    // The buffer absorbs a converter stall so no word is lost.
    // Its occupancy, looked at one edge ahead through busReady, is the only stall that the host ever sees.
    ao_skid_buffer buffer (
        .clk      (clk),
        .rstn     (rstn),
        .inValid  (fillValid),
        .inWord   (fillWord),
        .inReady  (fillReady),
        .outValid (drainValid),
        .outWord  (drainWord),
        .outReady (drainReady)
    );

    // Next converter codes, held values and status.
    always_comb begin
        logic                     wValid;
        dac_update_pkg::ao_word_t w;
        // The word to apply comes from the buffer drain or straight from the source.
        wValid          = useFifo ? (drainValid && drainReady) : srcValid;
        w               = useFifo ? drainWord : srcWord;
        next_held0      = held0;
        next_held1      = held1;
        next_dacCode0   = dacCode0;
        next_dacCode1   = dacCode1;
        // Load pulses last one cycle unless set again below.
        next_dacLoad    = 2'h0;
        // (R5) Polarity per channel
        next_dacBipolar = bipolarMode;
        // Back-pressure reaches the host only while the buffer is in use.
        // busReady is a register, so it must already tell whether the buffer
        // has room at the next edge; showing the present room instead would
        // let one write through that the full buffer then drops.
        next_busReady   = 1'b1;
        if (useFifo) begin
            // Full at the next edge: full now with no drain, or one word
            // plus a push with no drain.
            next_busReady = !((bufFull && !doDrain)
                              || (bufOne && fillValid && !doDrain));
        end
        // (R2) Immediate write applies
        if (wValid && immediate) begin
            if (w.channel) begin
                // Channel 1 takes the word.
                next_dacCode1   = w.code;
                next_dacLoad[1] = 1'b1;
            end else begin
                // Channel 0 takes the word.
                next_dacCode0   = w.code;
                next_dacLoad[0] = 1'b1;
            end
        end else if (wValid) begin
            // Posted mode only stores the value.
            // The converter keeps its code until the update event.
            if (w.channel) begin
                next_held1 = w.code;
            end else begin
                next_held0 = w.code;
            end
        end
        // (R3) Posted update applies both
        if (postedUpdate && (trigFall || updateStrobe)) begin
            // (R8) (R9) Code passes unchanged; polarity sets meaning
            // A write in the same cycle is included, so it is not lost.
            next_dacCode0 = next_held0;
            next_dacCode1 = next_held1;
            next_dacLoad  = 2'h3;
        end
    end

    // (R10) Register outputs with reset codes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Converters start at the zero code; the host may write at once.
            held0      <= `AO_CODE_RESET;
            held1      <= `AO_CODE_RESET;
            dacCode0   <= `AO_CODE_RESET;
            dacCode1   <= `AO_CODE_RESET;
            dacLoad    <= 2'h0;
            dacBipolar <= 2'h0;
            busReady   <= 1'b1;
            // Trigger history starts at the idle high level: no false fall.
            trigPrev   <= 1'b1;
        end else begin
            held0      <= next_held0;
            held1      <= next_held1;
            dacCode0   <= next_dacCode0;
            dacCode1   <= next_dacCode1;
            dacLoad    <= next_dacLoad;
            dacBipolar <= next_dacBipolar;
            busReady   <= next_busReady;
            // The pin level is kept one cycle for edge detection.
            trigPrev   <= timer_update_trigger_n;
        end
    end
endmodule // dual_dac_output_update
`default_nettype wire

//--- sim/ao_host_model.sv
// Purpose: Host side of the local bus that writes the converter registers.
// Assumes: Requests change at the falling edge and hold until taken.
// Notes:   A released bus shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module ao_host_model (
    // Clock and answer.
    input  wire logic        clk,
    input  wire logic        busReady,
    // Request.
    output logic             busWrite,
    output logic             busAccess,
    output logic [4:0]       busAddr,
    output logic [15:0]      busData
);
    initial begin
        busWrite = 1'b0;
        busAccess = 1'b0;
        busAddr = 5'h00;
        busData = 16'h0000;
    end
    // A write is held while busReady is low, since a refused write is dropped.
    task automatic write(input logic [4:0] a, input logic [15:0] d, input logic wr);
        @(negedge clk);
        busWrite = wr;
        busAccess = 1'b1;
        busAddr = a;
        busData = d;
        while (busReady !== 1'b1) @(negedge clk);
        @(negedge clk);
        busWrite = 1'b0;
        busAccess = 1'b0;
        busAddr = ~a;
        busData = ~d;
    endtask
endmodule // ao_host_model
`default_nettype wire

//--- sim/dual_dac_output_update_checker.sv
// Purpose: Port assertions for the dual output update block.
// Assumes: Mode 0 direct, 1 FIFO, 2 serial; offset 18 hex is the update strobe.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module dual_dac_output_update_checker (
    // Clock, reset and bus.
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        busWrite,
    input wire logic        busAccess,
    input wire logic [4:0]  busAddr,
    input wire logic [15:0] busData,
    // Settings, serial word and trigger.
    input wire logic [1:0]  pathMode,
    input wire logic        postedUpdate,
    input wire logic [1:0]  bipolarMode,
    input wire logic        serialValid,
    input wire logic        serialChannel,
    input wire logic [15:0] serialCode,
    input wire logic        timer_update_trigger_n,
    // Converter side.
    input wire logic [15:0] dacCode0,
    input wire logic [15:0] dacCode1,
    input wire logic [1:0]  dacLoad,
    input wire logic [1:0]  dacBipolar,
    input wire logic        busReady
);
    // Taken writes per channel, and the immediate direct setting.
    wire logic wr0 = busWrite && busAddr == 5'h10 && busReady;
    wire logic wr1 = busWrite && busAddr == 5'h12 && busReady;
    wire logic imm = !postedUpdate && pathMode == 2'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    reset_codes_a: assert property (!$past(rstn) |->
        dacCode0 == 16'h0000 && dacCode1 == 16'h0000 && dacLoad == 2'h0 && busReady)
        else $error("codes not cleared by reset");
    direct_ch0_a: assert property (imm && wr0 |=>
        dacCode0 == $past(busData) && dacLoad[0]) else $error("channel 0 write not applied");
    direct_ch1_a: assert property (imm && wr1 |=>
        dacCode1 == $past(busData) && dacLoad[1]) else $error("channel 1 write not applied");
    serial_load_a: assert property (!postedUpdate && pathMode == 2'h2 && serialValid |=>
        dacLoad[$past(serialChannel)]
        && ($past(serialChannel) ? dacCode1 : dacCode0) == $past(serialCode))
        else $error("serial word not applied");
    fifo_delay_a: assert property (!postedUpdate && pathMode == 2'h1 && wr0 |->
        ##1 !dacLoad[0] ##[1:12] dacLoad[0]) else $error("FIFO path bypassed or stuck");
    posted_strobe_a: assert property (postedUpdate && busAccess && busAddr == 5'h18
        |=> dacLoad == 2'h3) else $error("update strobe did not apply both channels");
    posted_hold_a: assert property (postedUpdate && wr0 && timer_update_trigger_n
        |=> !dacLoad[0]) else $error("posted write applied early");
    bipolar_copy_a: assert property ($past(rstn) |-> dacBipolar == $past(bipolarMode))
        else $error("polarity setting not reported");
    hold_code_a: assert property (!dacLoad[0] |-> $stable(dacCode0))
        else $error("channel 0 code changed without load");
endmodule // dual_dac_output_update_checker
bind dual_dac_output_update dual_dac_output_update_checker i_chk (.clk, .rstn, .busWrite,
    .busAccess, .busAddr, .busData, .pathMode, .postedUpdate, .bipolarMode, .serialValid,
    .serialChannel, .serialCode, .timer_update_trigger_n, .dacCode0, .dacCode1, .dacLoad,
    .dacBipolar, .busReady);
`default_nettype wire

//--- sim/testbench.sv
// Purpose: Self-checking bench for the dual output update block.
// Assumes: Random codes from an LFSR seeded at 82.
// Notes:   Covers direct, posted, serial and FIFO paths and a second reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module testbench;
    logic clk = 1'b0, rstn = 1'b0, busWrite, busAccess, busReady, postedUpdate = 1'b0;
    logic serialValid = 1'b0, serialChannel = 1'b0, trig = 1'b1, convReady = 1'b1;
    logic [1:0] pathMode = 2'h0, bipolarMode = 2'h0, dacLoad, dacBipolar;
    logic [4:0] busAddr;
    logic [15:0] busData, serialCode = 16'h0000, dacCode0, dacCode1, a, rnd = 16'h0052;
    logic [15:0] corner [4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
    int errors = 0, checked = 0, cycles = 0, taken, loads;
    always #5 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    ao_host_model i_ao_host_model (.clk, .busReady, .busWrite, .busAccess, .busAddr, .busData);
    dual_dac_output_update i_dual_dac_output_update (.clk, .rstn, .busWrite, .busAccess,
        .busAddr, .busData, .pathMode, .postedUpdate, .bipolarMode, .serialValid,
        .serialChannel, .serialCode, .timer_update_trigger_n(trig), .convReady, .dacCode0,
        .dacCode1, .dacLoad, .dacBipolar, .busReady);
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // A hang counts as a mismatch and closes the run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        `CHK("reset code", 16'h0000, dacCode0)
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            a = (i < 4) ? corner[i] : rnd;
            bipolarMode = rnd[1:0];
            i_ao_host_model.write(i[0] ? 5'h12 : 5'h10, a, 1'b1);
            `CHK("direct code", a, i[0] ? dacCode1 : dacCode0)
            `CHK("polarity", bipolarMode, dacBipolar)
        end
        $display("test direct done");
        postedUpdate = 1'b1;
        a = lfsr(rnd);
        i_ao_host_model.write(5'h10, a, 1'b1);
        i_ao_host_model.write(5'h12, ~a, 1'b1);
        `CHK("posted hold", rnd, dacCode1)
        i_ao_host_model.write(5'h18, 16'h0000, 1'b0);
        `CHK("strobe code", {a, ~a}, {dacCode0, dacCode1})
        i_ao_host_model.write(5'h10, rnd, 1'b1);
        trig = 1'b0;
        for (int k = 0; k < 8 && dacLoad[0] !== 1'b1; k++) @(negedge clk);
        `CHK("trigger code", rnd, dacCode0)
        trig = 1'b1;
        postedUpdate = 1'b0;
        $display("test posted done");
        pathMode = 2'h2;
        for (int c = 0; c < 2; c++) begin
            rnd = lfsr(rnd);
            {serialValid, serialChannel, serialCode} = {1'b1, c[0], rnd};
            @(negedge clk);
            {serialValid, serialCode} = {1'b0, ~rnd};
            `CHK("serial code", rnd, c[0] ? dacCode1 : dacCode0)
            @(negedge clk);
        end
        $display("test serial done");
        // The converter stalls while the buffer fills, then drains it.
        {pathMode, convReady, taken, loads} = {2'h1, 1'b0, 32'd0, 32'd0};
        while (busReady === 1'b1 && taken < 4) begin
            rnd = lfsr(rnd);
            i_ao_host_model.write(5'h10, rnd, 1'b1);
            taken++;
        end
        `CHK("buffer full", 1'b0, busReady)
        `CHK("taken words", 2, taken)
        convReady = 1'b1;
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            if (dacLoad[0] === 1'b1) loads++;
        end
        `CHK("drained words", taken, loads)
        `CHK("fifo code", rnd, dacCode0)
        $display("test fifo done");
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        `CHK("second reset", 32'h0, {dacCode0, dacCode1})
        $display("test reset done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
